// ---- include/cscc_pkg.sv ----
`default_nettype none
package cscc_pkg;
    // Register byte addresses on the APB slave.
    localparam logic [7:0] CSCC_ADDR_RATE = 8'h04;
    localparam logic [7:0] CSCC_ADDR_GAIN = 8'h08;
    localparam logic [7:0] CSCC_ADDR_OFFS = 8'h0c;
    localparam logic [7:0] CSCC_ADDR_GCAL = 8'h10;
    localparam logic [7:0] CSCC_ADDR_STAT = 8'h14;
    localparam logic [7:0] CSCC_ADDR_RSLT = 8'h18;
    // Field positions.
    localparam int CSCC_RATE_LSB   = 0;
    localparam int CSCC_SINC_BIT   = 4;
    localparam int CSCC_SINGLE_BIT = 5;
    localparam int CSCC_CHOP_BIT   = 6;
    localparam int CSCC_DELAY_LSB  = 5;
    // Reset values.
    localparam logic [7:0]  CSCC_RATE_RST = 8'h00;
    localparam logic [7:0]  CSCC_GAIN_RST = 8'h00;
    localparam logic [23:0] CSCC_OFFS_RST = 24'h000000;
    localparam logic [15:0] CSCC_GCAL_RST = 16'h8000;
    // Timing, in device clocks or modulator periods; discard count in conversions; gain shift in bits.
    localparam int          CSCC_MOD_CLKS      = 16;
    localparam logic [17:0] CSCC_DELAY_DEFAULT = 18'h0000e;
    localparam logic [17:0] CSCC_OVH_MODS      = 18'h00008;
    localparam logic [1:0]  CSCC_DISCARDS      = 2'h2;
    localparam int          CSCC_GAIN_SHIFT    = 15;

    typedef enum logic [1:0] {
        CSCC_IDLE  = 2'b00,
        CSCC_DELAY = 2'b01,
        CSCC_SAMPLE = 2'b11,
        CSCC_OVHD  = 2'b10
    } cscc_state_t;

    typedef struct packed {
        logic run;
        logic reverse;
        logic comp;
    } cscc_mod_ctl_t;

    typedef struct packed {
        logic       chop;
        logic       single;
        logic       sinc;
        logic [3:0] rate;
    } cscc_cfg_t;

    // Settling delay in modulator periods for each delay code.
    function automatic logic [17:0] cscc_delay_mods(input logic [2:0] code);
        case (code)
            3'h0: cscc_delay_mods = CSCC_DELAY_DEFAULT;
            3'h1: cscc_delay_mods = 18'h00019;
            3'h2: cscc_delay_mods = 18'h00040;
            3'h3: cscc_delay_mods = 18'h00100;
            3'h4: cscc_delay_mods = 18'h00400;
            3'h5: cscc_delay_mods = 18'h00800;
            3'h6: cscc_delay_mods = 18'h01000;
            default: cscc_delay_mods = 18'h00001;
        endcase
    endfunction

    // Normal data period in modulator periods for each rate code.
    function automatic logic [17:0] cscc_period_mods(input logic [3:0] rate);
        case (rate)
            4'h0: cscc_period_mods = 18'h19000;
            4'h1: cscc_period_mods = 18'h0c800;
            4'h2: cscc_period_mods = 18'h06400;
            4'h3: cscc_period_mods = 18'h03c00;
            4'h4: cscc_period_mods = 18'h03200;
            4'h5: cscc_period_mods = 18'h01400;
            4'h6: cscc_period_mods = 18'h010a8;
            4'h7: cscc_period_mods = 18'h00a00;
            4'h8: cscc_period_mods = 18'h00500;
            4'h9: cscc_period_mods = 18'h00280;
            4'ha: cscc_period_mods = 18'h00140;
            4'hb: cscc_period_mods = 18'h00100;
            4'hc: cscc_period_mods = 18'h00080;
            default: cscc_period_mods = 18'h00040;
        endcase
    endfunction
endpackage
`default_nettype wire

// ---- logic/cscc_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module cscc_timer #(
    parameter int MOD_DIV = 16
) (
    input  wire logic        pclk,     // Clock.
    input  wire logic        presetn,  // Asynchronous reset, active low.
    input  wire logic        load,     // Start a new interval.
    input  wire logic [17:0] load_val, // Interval length in modulator periods.
    output logic             done      // One-cycle pulse at interval end.
);
    logic [15:0] pre_reg;
    logic [17:0] cnt_reg;
    logic        tick;

    assign tick = (pre_reg == 16'(MOD_DIV - 1));

    // The end pulse is decoded from the last tick, not registered, so that the reload
    // lands on the final modulator edge and back-to-back intervals add up exactly.
    assign done = tick && (cnt_reg == 18'h00001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 16'h0000;
        end else if (load || tick) begin
            pre_reg <= 16'h0000;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 18'h00000;
        end else begin
            if (load) begin
                cnt_reg <= load_val;
            end else if (tick && cnt_reg != 18'h00000) begin
                cnt_reg <= cnt_reg - 18'h00001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/cscc_seq.sv ----
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cscc_seq #(
    parameter int MOD_DIV = cscc_pkg::CSCC_MOD_CLKS
) (
    input  wire logic                  pclk,      // APB and device clock.
    input  wire logic                  presetn,   // Asynchronous reset, active low.
    input  wire logic                  psel,      // APB select.
    input  wire logic                  penable,   // APB enable.
    input  wire logic                  pwrite,    // APB direction.
    input  wire logic [7:0]            paddr,     // APB byte address.
    input  wire logic [31:0]           pwdata,    // APB write data.
    output logic [31:0]                prdata,    // APB read data.
    output logic                       pready,    // APB ready.
    output logic                       pslverr,   // APB error on unmapped address.
    input  wire logic                  start_pin, // Conversion trigger pin.
    input  wire logic                  start_cmd, // Start command strobe.
    input  wire logic [23:0]           raw_data,  // Filter result at sampling end.
    output cscc_pkg::cscc_mod_ctl_t    mod_ctl,   // Modulator control.
    output logic                       drdy,      // New result pulse.
    output logic [23:0]                data_out   // Latest corrected result.
);
    import cscc_pkg::*;

    cscc_state_t   state_reg;
    cscc_state_t   state_next;
    cscc_cfg_t     cfg;
    logic [7:0]    rate_reg;
    logic [7:0]    gain_reg;
    logic [23:0]   offs_reg;
    logic [15:0]   gcal_reg;
    logic          pin_q_reg;
    logic          start;
    logic          tdone;
    logic          tload;
    logic [17:0]   tval;
    logic [1:0]    disc_reg;
    logic          have_prev_reg;
    logic          pair_first_reg;
    logic          newdata_reg;
    logic [23:0]   acc_reg;
    logic [23:0]   prev_reg;
    logic signed [24:0] comp_diff;
    logic signed [40:0] comp_prod;
    logic [23:0]   comp_val;
    logic [24:0]   chop_diff;
    logic [23:0]   chop_avg;
    logic          apb_wr;
    logic          apb_setup;
    logic          rslt_rd;
    logic          skip_ovhd;
    logic [17:0]   sample_len;

    assign cfg = cscc_cfg_t'({rate_reg[CSCC_CHOP_BIT], rate_reg[CSCC_SINGLE_BIT],
                              rate_reg[CSCC_SINC_BIT], rate_reg[CSCC_RATE_LSB +: 4]});

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == CSCC_ADDR_RATE) || (a == CSCC_ADDR_GAIN) ||
                     (a == CSCC_ADDR_OFFS) || (a == CSCC_ADDR_GCAL) ||
                     (a == CSCC_ADDR_STAT) || (a == CSCC_ADDR_RSLT);
    endfunction

    // APB: ready is raised at the setup edge, so every access completes with no wait state.
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pready && pwrite && addr_known(paddr);
    assign rslt_rd   = psel && penable && pready && !pwrite && (paddr == CSCC_ADDR_RSLT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !addr_known(paddr);
            if (apb_setup && !pwrite) begin
                case (paddr)
                    CSCC_ADDR_RATE: prdata <= {24'h000000, rate_reg};
                    CSCC_ADDR_GAIN: prdata <= {24'h000000, gain_reg};
                    CSCC_ADDR_OFFS: prdata <= {8'h00, offs_reg};
                    CSCC_ADDR_GCAL: prdata <= {16'h0000, gcal_reg};
                    CSCC_ADDR_STAT: prdata <= {27'h0000000, have_prev_reg, newdata_reg,
                                               mod_ctl.reverse, state_reg};
                    CSCC_ADDR_RSLT: prdata <= {8'h00, data_out};
                    default:        prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_reg <= CSCC_RATE_RST;
            gain_reg <= CSCC_GAIN_RST;
            offs_reg <= CSCC_OFFS_RST;
            gcal_reg <= CSCC_GCAL_RST;
        end else if (apb_wr) begin
            case (paddr)
                CSCC_ADDR_RATE: rate_reg <= pwdata[7:0];
                CSCC_ADDR_GAIN: gain_reg <= pwdata[7:0];
                CSCC_ADDR_OFFS: offs_reg <= pwdata[23:0];
                CSCC_ADDR_GCAL: gcal_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // The pin is taken as synchronous, so one stage of history is enough for the edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q_reg <= 1'b0;
        end else begin
            pin_q_reg <= start_pin;
        end
    end

    assign start = (start_pin && !pin_q_reg) || start_cmd;

    // Sampling plus overhead fills exactly one data period.
    assign sample_len = cscc_period_mods(cfg.rate) - CSCC_OVH_MODS;
    assign skip_ovhd  = cfg.sinc && (disc_reg != CSCC_DISCARDS);

    always_comb begin
        state_next = state_reg;
        tload      = 1'b0;
        tval       = sample_len;
        if (start) begin
            state_next = CSCC_DELAY;
            tload      = 1'b1;
            tval       = cscc_delay_mods(gain_reg[CSCC_DELAY_LSB +: 3]);
        end else if (tdone) begin
            case (state_reg)
                CSCC_DELAY: begin
                    state_next = CSCC_SAMPLE;
                    tload      = 1'b1;
                end
                CSCC_SAMPLE: begin
                    tload = 1'b1;
                    if (skip_ovhd) begin
                        state_next = CSCC_SAMPLE;
                    end else begin
                        state_next = CSCC_OVHD;
                        tval       = CSCC_OVH_MODS;
                    end
                end
                CSCC_OVHD: begin
                    if (cfg.chop && !have_prev_reg && pair_first_reg) begin
                        state_next = CSCC_DELAY;
                        tload      = 1'b1;
                        tval       = cscc_delay_mods(gain_reg[CSCC_DELAY_LSB +: 3]);
                    end else if (cfg.single) begin
                        state_next = CSCC_IDLE;
                    end else begin
                        state_next = CSCC_SAMPLE;
                        tload      = 1'b1;
                    end
                end
                default: state_next = CSCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CSCC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    cscc_timer #(
        .MOD_DIV (MOD_DIV)
    ) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tload),
        .load_val (tval),
        .done     (tdone)
    );

    // Discard count restarts with each start and each polarity flip, so a sinc chop pair
    // settles twice: about six conversions before the first average.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disc_reg <= 2'h0;
        end else if (start) begin
            disc_reg <= 2'h0;
        end else if (tdone && state_reg == CSCC_SAMPLE && skip_ovhd) begin
            disc_reg <= disc_reg + 2'h1;
        end else if (tdone && state_reg == CSCC_OVHD && cfg.chop) begin
            disc_reg <= 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 24'h000000;
        end else if (tdone && state_reg == CSCC_SAMPLE && !skip_ovhd) begin
            acc_reg <= raw_data;
        end
    end

    // Offset removal, then gain in Q1.15; the product is truncated, not rounded.
    assign comp_diff = $signed({acc_reg[23], acc_reg}) - $signed({offs_reg[23], offs_reg});
    assign comp_prod = comp_diff * $signed({1'b0, gcal_reg});
    assign comp_val  = comp_prod[CSCC_GAIN_SHIFT +: 24];

    // The reversed conversion carries the signal negated, so its sign is undone here.
    assign chop_diff = mod_ctl.reverse ?
                       ({prev_reg[23], prev_reg} - {comp_val[23], comp_val}) :
                       ({comp_val[23], comp_val} - {prev_reg[23], prev_reg});
    assign chop_avg  = chop_diff[24:1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_ctl        <= '0;
            have_prev_reg  <= 1'b0;
            pair_first_reg <= 1'b0;
            prev_reg       <= 24'h000000;
        end else begin
            mod_ctl.run  <= (state_next == CSCC_SAMPLE);
            mod_ctl.comp <= (state_next == CSCC_OVHD);
            if (start) begin
                mod_ctl.reverse <= 1'b0;
                have_prev_reg   <= 1'b0;
                pair_first_reg  <= 1'b1;
            end else if (tdone && state_reg == CSCC_OVHD && cfg.chop) begin
                mod_ctl.reverse <= !mod_ctl.reverse;
                prev_reg        <= comp_val;
                have_prev_reg   <= 1'b1;
                pair_first_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drdy     <= 1'b0;
            data_out <= 24'h000000;
        end else begin
            drdy <= 1'b0;
            if (tdone && !start && state_reg == CSCC_OVHD) begin
                if (!cfg.chop) begin
                    drdy     <= 1'b1;
                    data_out <= comp_val;
                end else if (have_prev_reg) begin
                    drdy     <= 1'b1;
                    data_out <= chop_avg;
                end
            end
        end
    end

    // A new result beats a read of the result register in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            newdata_reg <= 1'b0;
        end else if (tdone && !start && state_reg == CSCC_OVHD &&
                     (!cfg.chop || have_prev_reg)) begin
            newdata_reg <= 1'b1;
        end else if (rslt_rd) begin
            newdata_reg <= 1'b0;
        end
    end

    start_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> state_reg == CSCC_DELAY ##0 !mod_ctl.run)
        else $error("start did not enter the settling delay");

    delay_default_a: assert property (@(posedge pclk) disable iff (!presetn)
        (start && gain_reg[CSCC_DELAY_LSB +: 3] == 3'h0) |-> tload && tval == 18'h0000e)
        else $error("default delay is not 14 modulator periods");

    delay_then_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == CSCC_DELAY && state_next != CSCC_DELAY && !start)
        |=> state_reg == CSCC_SAMPLE)
        else $error("delay not followed by sampling");

    discard_no_ovhd_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == CSCC_SAMPLE && $past(state_reg) == CSCC_SAMPLE) |->
        !(state_next == CSCC_OVHD && cfg.sinc && disc_reg < CSCC_DISCARDS))
        else $error("withheld sinc result entered overhead");

    drdy_from_ovhd_a: assert property (@(posedge pclk) disable iff (!presetn)
        drdy |-> $past(state_reg) == CSCC_OVHD && $past(tdone))
        else $error("result presented without overhead");

    single_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (drdy && cfg.single && !$past(start)) |-> state_reg == CSCC_IDLE ##1
        (state_reg == CSCC_IDLE || $past(start)))
        else $error("single-shot kept converting");

    cont_no_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        (drdy && !cfg.single && !$past(start)) |-> state_reg == CSCC_SAMPLE)
        else $error("continuous reading repeated the delay");

    chop_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tdone && state_reg == CSCC_OVHD && cfg.chop && !start) |=>
        mod_ctl.reverse != $past(mod_ctl.reverse))
        else $error("chop polarity did not alternate");

    chop_avg_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tdone && state_reg == CSCC_OVHD && cfg.chop && have_prev_reg && !start) |=>
        drdy && data_out == $past(chop_avg))
        else $error("chop result is not the pair average");

    run_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        mod_ctl.run == (state_reg == CSCC_SAMPLE))
        else $error("modulator run flag disagrees with the sampling phase");

    comp_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        mod_ctl.comp == (state_reg == CSCC_OVHD))
        else $error("compensation flag disagrees with the overhead phase");

    sinc_withhold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tdone && state_reg == CSCC_SAMPLE && cfg.sinc && disc_reg < CSCC_DISCARDS && !start)
        |=> !drdy && state_reg == CSCC_SAMPLE)
        else $error("unsettled sinc result was not withheld");

    chop_redelay_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tdone && state_reg == CSCC_OVHD && cfg.chop && pair_first_reg && !start) |=>
        state_reg == CSCC_DELAY && !drdy)
        else $error("chop pair did not repeat the settling delay");
endmodule
`default_nettype wire

// ---- sim/cscc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cscc_host_model (
    input  wire logic                    pclk,      // Device clock.
    input  wire cscc_pkg::cscc_mod_ctl_t mod_ctl,   // Modulator control from the block.
    output logic                         start_pin, // Conversion trigger pin.
    output logic                         start_cmd, // Start command strobe.
    output logic [23:0]                  raw_data   // Filter result seen by the block.
);
    import cscc_pkg::*;
    // A signal of 120h plus an offset of 20h, so only a true average cancels the offset.
    localparam logic [23:0] NORM_VAL = 24'h000140;
    localparam logic [23:0] REV_VAL  = 24'hffff00;
    initial begin
        start_pin = 1'b0;
        start_cmd = 1'b0;
    end
    assign raw_data = mod_ctl.reverse ? REV_VAL : NORM_VAL;
    // A trigger is a one-cycle pin pulse or a one-cycle start command strobe.
    task automatic kick(input logic use_pin);
        @(posedge pclk);
        if (use_pin) start_pin <= 1'b1;
        else start_cmd <= 1'b1;
        @(posedge pclk);
        start_pin <= 1'b0;
        start_cmd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sim/test_conversion_sequencer_chop.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_conversion_sequencer_chop;
    import cscc_pkg::*;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, rd;
    logic          pready, pslverr, start_pin, start_cmd, drdy, err;
    logic [23:0]   raw_data, data_out;
    cscc_mod_ctl_t mod_ctl;
    int            miscompares = 0, comparisons = 0, n, n2;
    always #2.5 pclk = ~pclk;
    cscc_seq #(.MOD_DIV(1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_pin(start_pin), .start_cmd(start_cmd),
        .raw_data(raw_data), .mod_ctl(mod_ctl), .drdy(drdy), .data_out(data_out));
    cscc_host_model u_host (.pclk(pclk), .mod_ctl(mod_ctl), .start_pin(start_pin),
        .start_cmd(start_cmd), .raw_data(raw_data));
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic wait_drdy(output int c);
        c = 0;
        do begin
            @(posedge pclk);
            #1;
            c++;
        end while (drdy !== 1'b1 && c < 2000);
        if (c >= 2000) begin
            miscompares++;
            end_of_test();
        end
    endtask
    // Start, then accept a few cycles of trigger latency around the nominal count.
    task automatic first_drdy(input logic pin, input int e);
        u_host.kick(pin);
        wait_drdy(n);
        `CHK((n + 2 >= e) && (n <= e + 6), 1'b1)
    endtask
    task automatic t_regs();
        do_reset();
        apb(1'b0, CSCC_ADDR_RATE, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b0, CSCC_ADDR_GCAL, 32'h0);
        `CHK(rd, 32'h00008000)
        apb(1'b1, 8'h40, 32'hffffffff);
        `CHK(err, 1'b1)
        apb(1'b1, CSCC_ADDR_RATE, 32'h0000004d);
        apb(1'b0, CSCC_ADDR_RATE, 32'h0);
        `CHK(rd[7:0], 8'h4d)
        apb(1'b1, CSCC_ADDR_STAT, 32'hffffffff);
        apb(1'b0, CSCC_ADDR_STAT, 32'h0);
        `CHK(rd[1:0], 2'h0)
        $display("test regs done");
    endtask
    task automatic t_delay();
        for (int code = 0; code < 8; code += 7) begin
            do_reset();
            apb(1'b1, CSCC_ADDR_RATE, 32'h0000000d);
            apb(1'b1, CSCC_ADDR_GAIN, code << CSCC_DELAY_LSB);
            first_drdy(code == 7, (code == 7 ? 1 : 14) + 64);
            `CHK(data_out, 24'h000140)
            wait_drdy(n);
            `CHK(n, 64)
        end
        $display("test delay done");
    endtask
    task automatic t_comp();
        do_reset();
        apb(1'b1, CSCC_ADDR_RATE, 32'h0000000d);
        apb(1'b1, CSCC_ADDR_OFFS, 32'h00000010);
        apb(1'b1, CSCC_ADDR_GCAL, 32'h00004000);
        first_drdy(1'b0, 78);
        `CHK(data_out, 24'h000098)
        $display("test comp done");
    endtask
    task automatic t_sinc();
        do_reset();
        apb(1'b1, CSCC_ADDR_RATE, 32'h0000001d);
        first_drdy(1'b1, 190);
        wait_drdy(n);
        `CHK(n, 64)
        $display("test sinc done");
    endtask
    task automatic t_single();
        do_reset();
        apb(1'b1, CSCC_ADDR_RATE, 32'h0000002d);
        first_drdy(1'b0, 78);
        n = 0;
        repeat (300) begin
            @(posedge pclk);
            #1;
            n += drdy;
        end
        `CHK(n, 0)
        `CHK(mod_ctl, 3'h0)
        apb(1'b0, CSCC_ADDR_STAT, 32'h0);
        `CHK(rd[1:0], 2'h0)
        $display("test single done");
    endtask
    task automatic t_chop();
        do_reset();
        apb(1'b1, CSCC_ADDR_RATE, 32'h0000004d);
        first_drdy(1'b1, 156);
        `CHK(data_out, 24'h000120)
        wait_drdy(n);
        `CHK(data_out, 24'h000120)
        `CHK(2 * n, 156 - 2 * 14)
        wait_drdy(n2);
        `CHK(n2, n)
        do_reset();
        apb(1'b1, CSCC_ADDR_RATE, 32'h0000005d);
        first_drdy(1'b0, 380);
        `CHK(data_out, 24'h000120)
        $display("test chop done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_delay();
        t_comp();
        t_sinc();
        t_single();
        t_chop();
        end_of_test();
    end
endmodule
`default_nettype wire
